// [src/cbt_pkg.sv]
package cbt_pkg;

  // ==========================================================
  // Register offsets (SFR addresses)
  localparam logic [7:0] ADDR_PAGE = 8'hB1;
  localparam logic [7:0] ADDR_BT1 = 8'hB4;
  localparam logic [7:0] ADDR_BT2 = 8'hB5;
  localparam logic [7:0] ADDR_BT3 = 8'hB6;
  localparam logic [7:0] ADDR_IE1 = 8'hC2;
  localparam logic [7:0] ADDR_IE2 = 8'hC3;

  // ==========================================================
  // Field positions
  localparam int PSC_LSB = 1;
  localparam int JMP_LSB = 5;
  localparam int PRG_LSB = 1;
  localparam int PH2_LSB = 4;
  localparam int PH1_LSB = 1;
  localparam int SAMP_BIT = 0;
  localparam int OBJ_LSB = 4;
  localparam int HOLD_BIT = 3;
  localparam int IDX_LSB = 0;

  // ==========================================================
  // Reset values
  localparam logic [6:0] IE1_RESET = 7'h00;
  localparam logic [7:0] IE2_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] BT_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [5:0] quantum_prescaler;
    logic [1:0] resync_jump_width;
    logic [2:0] propagation_segment;
    logic [2:0] phase_segment_one;
    logic [2:0] phase_segment_two;
    logic triple_sample_select;
  } cbt_cfg_s;

  typedef struct packed {
    logic [3:0] object_select;
    logic index_hold_n;
    logic [2:0] data_byte_index;
  } cbt_page_s;

  typedef enum logic [2:0] {
    ST_SYNC = 3'b001,
    ST_SEG1 = 3'b010,
    ST_SEG2 = 3'b100
  } cbt_bit_e;

endpackage

// [src/cbt_bit_timer.sv]
`timescale 1ns/1ns
module cbt_bit_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_enable,
  input wire cbt_pkg::cbt_cfg_s i_cfg,
  // Synchronised bus level
  input wire logic i_rx,
  // Bit timing results
  output logic o_bit_start,
  output logic o_sample_point,
  output logic o_rx_bit
);

  // ==========================================================
  // State
  cbt_pkg::cbt_bit_e st_r, st_nxt;
  logic [5:0] presc_r, presc_nxt;
  logic [4:0] tq_r, tq_nxt;
  logic [2:0] ext_r, ext_nxt;
  logic [2:0] shr_r, shr_nxt;
  logic done_r, done_nxt;
  logic prev_r, prev_nxt;
  logic [1:0] hist_r, hist_nxt;
  logic start_r, start_nxt;
  logic spt_r, spt_nxt;
  logic bit_r, bit_nxt;

  function automatic logic [2:0] min3(input logic [4:0] a,
                                      input logic [2:0] b);
    min3 = (a < {2'b00, b}) ? a[2:0] : b;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic tick;
    logic half;
    logic edge_seen;
    logic [2:0] jw;
    logic [4:0] seg1_len;
    logic [4:0] seg2_len;
    seg1_len = 5'h00;
    seg2_len = 5'h00;
    tick = (presc_r == i_cfg.quantum_prescaler);
    half = (presc_r == {1'b0, i_cfg.quantum_prescaler[5:1]});
    jw = {1'b0, i_cfg.resync_jump_width} + 3'h1;
    edge_seen = prev_r & ~i_rx & ~done_r;
    st_nxt = st_r;
    tq_nxt = tq_r;
    ext_nxt = ext_r;
    shr_nxt = shr_r;
    done_nxt = done_r;
    start_nxt = 1'b0;
    spt_nxt = 1'b0;
    bit_nxt = bit_r;
    prev_nxt = i_rx;
    presc_nxt = tick ? 6'h00 : presc_r + 6'h01;
    hist_nxt = (tick | half) ? {hist_r[0], i_rx} : hist_r;
    // Late edge lengthens seg1, early edge shortens seg2
    if (edge_seen && st_r == cbt_pkg::ST_SEG1) begin
      ext_nxt = min3(tq_r + 5'h01, jw);
      done_nxt = 1'b1;
    end else if (edge_seen && st_r == cbt_pkg::ST_SEG2) begin
      shr_nxt = jw;
      done_nxt = 1'b1;
    end
    seg1_len = 5'({2'b00, i_cfg.propagation_segment} + 5'h01)
             + 5'({2'b00, i_cfg.phase_segment_one} + 5'h01)
             + {2'b00, ext_nxt};
    seg2_len = {2'b00, i_cfg.phase_segment_two} + 5'h01;
    if (tick) begin
      unique case (st_r)
        cbt_pkg::ST_SYNC: begin
          st_nxt = cbt_pkg::ST_SEG1;
          tq_nxt = 5'h00;
        end
        cbt_pkg::ST_SEG1: begin
          if (tq_r + 5'h01 >= seg1_len) begin
            st_nxt = cbt_pkg::ST_SEG2;
            tq_nxt = 5'h00;
            spt_nxt = 1'b1;
            if (i_cfg.triple_sample_select) begin
              bit_nxt = (hist_r[1] & hist_r[0]) | (hist_r[1] & i_rx)
                      | (hist_r[0] & i_rx);
            end else begin
              bit_nxt = i_rx;
            end
          end else begin
            tq_nxt = tq_r + 5'h01;
          end
        end
        cbt_pkg::ST_SEG2: begin
          if (tq_r + 5'h01 + {2'b00, shr_nxt} >= seg2_len) begin
            st_nxt = cbt_pkg::ST_SYNC;
            tq_nxt = 5'h00;
            ext_nxt = 3'h0;
            shr_nxt = 3'h0;
            done_nxt = 1'b0;
            start_nxt = 1'b1;
          end else begin
            tq_nxt = tq_r + 5'h01;
          end
        end
      endcase
    end
    if (!i_enable) begin
      st_nxt = cbt_pkg::ST_SYNC;
      presc_nxt = 6'h00;
      tq_nxt = 5'h00;
      ext_nxt = 3'h0;
      shr_nxt = 3'h0;
      done_nxt = 1'b0;
      start_nxt = 1'b0;
      spt_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= cbt_pkg::ST_SYNC;
      presc_r <= 6'h00;
      tq_r <= 5'h00;
      ext_r <= 3'h0;
      shr_r <= 3'h0;
      done_r <= 1'b0;
      prev_r <= 1'b1;
      hist_r <= 2'h3;
      start_r <= 1'b0;
      spt_r <= 1'b0;
      bit_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      presc_r <= presc_nxt;
      tq_r <= tq_nxt;
      ext_r <= ext_nxt;
      shr_r <= shr_nxt;
      done_r <= done_nxt;
      prev_r <= prev_nxt;
      hist_r <= hist_nxt;
      start_r <= start_nxt;
      spt_r <= spt_nxt;
      bit_r <= bit_nxt;
    end
  end

  assign o_bit_start = start_r;
  assign o_sample_point = spt_r;
  assign o_rx_bit = bit_r;

endmodule

// [src/cbt_top.sv]
`timescale 1ns/1ns
module cbt_top #(
  parameter int NUM_OBJ = 15
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // SFR access port
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  // Controller state and frame engine events
  input wire logic I_CONTROLLER_ENABLE,
  input wire logic [NUM_OBJ-1:0] I_OBJ_IRQ_STATUS,
  input wire logic I_DATA_ACCESS,
  // CAN receive pin
  input wire logic I_CAN_RX,
  // Page outputs
  output logic [3:0] O_OBJECT_SELECT,
  output logic [2:0] O_DATA_BYTE_INDEX,
  // Interrupt outputs
  output logic [NUM_OBJ-1:0] O_OBJ_IRQ,
  output logic O_CAN_IRQ,
  // Bit timing outputs
  output logic O_BIT_START,
  output logic O_SAMPLE_POINT,
  output logic O_RX_BIT
);

  if (NUM_OBJ != 15) begin : g_num_obj_check
    $error("NUM_OBJ must be 15");
  end

  // ==========================================================
  // Register state
  cbt_pkg::cbt_cfg_s cfg_r, cfg_nxt;
  cbt_pkg::cbt_page_s page_r, page_nxt;
  logic [6:0] ie_high_r, ie_high_nxt;
  logic [7:0] ie_low_r, ie_low_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [NUM_OBJ-1:0] irq_r, irq_nxt;
  logic any_r, any_nxt;
  logic [1:0] rx_sync_r;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ==========================================================
  // Next values
  always_comb begin
    logic [NUM_OBJ-1:0] en;
    en = '0;
    cfg_nxt = cfg_r;
    page_nxt = page_r;
    ie_high_nxt = ie_high_r;
    ie_low_nxt = ie_low_r;
    rdata_nxt = rdata_r;
    // Index advance after each data window access while index_hold_n is clear
    if (I_DATA_ACCESS && !page_r.index_hold_n) begin
      page_nxt.data_byte_index = page_r.data_byte_index + 3'h1;
    end
    if (I_SFR_WR) begin
      // Reserved bit positions are not stored
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_PAGE)) begin
        page_nxt.object_select = I_SFR_WDATA[cbt_pkg::OBJ_LSB +: 4];
        page_nxt.index_hold_n = I_SFR_WDATA[cbt_pkg::HOLD_BIT];
        page_nxt.data_byte_index = I_SFR_WDATA[cbt_pkg::IDX_LSB +: 3];
      end
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_BT1)) begin
        cfg_nxt.quantum_prescaler = I_SFR_WDATA[cbt_pkg::PSC_LSB +: 6];
      end
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_BT2)) begin
        cfg_nxt.resync_jump_width = I_SFR_WDATA[cbt_pkg::JMP_LSB +: 2];
        cfg_nxt.propagation_segment = I_SFR_WDATA[cbt_pkg::PRG_LSB +: 3];
      end
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_BT3)) begin
        cfg_nxt.phase_segment_two = I_SFR_WDATA[cbt_pkg::PH2_LSB +: 3];
        cfg_nxt.phase_segment_one = I_SFR_WDATA[cbt_pkg::PH1_LSB +: 3];
        cfg_nxt.triple_sample_select = I_SFR_WDATA[cbt_pkg::SAMP_BIT];
      end
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_IE1)) begin
        ie_high_nxt = I_SFR_WDATA[6:0];
      end
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_IE2)) begin
        ie_low_nxt = I_SFR_WDATA;
      end
    end
    if (I_SFR_RD) begin
      // Reserved bits read back as zero
      if (hit(I_SFR_ADDR, cbt_pkg::ADDR_PAGE)) begin
        rdata_nxt = page_r;
      end else if (hit(I_SFR_ADDR, cbt_pkg::ADDR_BT1)) begin
        rdata_nxt = {1'b0, cfg_r.quantum_prescaler, 1'b0};
      end else if (hit(I_SFR_ADDR, cbt_pkg::ADDR_BT2)) begin
        rdata_nxt = {1'b0, cfg_r.resync_jump_width, 1'b0,
                     cfg_r.propagation_segment, 1'b0};
      end else if (hit(I_SFR_ADDR, cbt_pkg::ADDR_BT3)) begin
        rdata_nxt = {1'b0, cfg_r.phase_segment_two,
                     cfg_r.phase_segment_one,
                     cfg_r.triple_sample_select};
      end else if (hit(I_SFR_ADDR, cbt_pkg::ADDR_IE1)) begin
        rdata_nxt = {1'b0, ie_high_r};
      end else if (hit(I_SFR_ADDR, cbt_pkg::ADDR_IE2)) begin
        rdata_nxt = ie_low_r;
      end else begin
        rdata_nxt = cbt_pkg::RD_UNMAPPED;
      end
    end
    // Object interrupts follow the level status, gated by enables
    en = {ie_high_r, ie_low_r};
    irq_nxt = I_OBJ_IRQ_STATUS & en;
    any_nxt = |irq_nxt;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cfg_r <= cbt_pkg::cbt_cfg_s'({cbt_pkg::BT_RESET[5:0],
                                    cbt_pkg::BT_RESET,
                                    cbt_pkg::BT_RESET[3:0]});
      page_r <= cbt_pkg::PAGE_RESET;
      ie_high_r <= cbt_pkg::IE1_RESET;
      ie_low_r <= cbt_pkg::IE2_RESET;
      rdata_r <= cbt_pkg::RD_UNMAPPED;
      irq_r <= '0;
      any_r <= 1'b0;
      rx_sync_r <= 2'h3;
    end else begin
      cfg_r <= cfg_nxt;
      page_r <= page_nxt;
      ie_high_r <= ie_high_nxt;
      ie_low_r <= ie_low_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      any_r <= any_nxt;
      rx_sync_r <= {rx_sync_r[0], I_CAN_RX};
    end
  end

  // ==========================================================
  // Bit timing engine, runs only while the controller is enabled
  cbt_bit_timer u_timer (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_enable(I_CONTROLLER_ENABLE),
    .i_cfg(cfg_r),
    .i_rx(rx_sync_r[1]),
    .o_bit_start(O_BIT_START),
    .o_sample_point(O_SAMPLE_POINT),
    .o_rx_bit(O_RX_BIT)
  );

  assign O_SFR_RDATA = rdata_r;
  assign O_OBJECT_SELECT = page_r.object_select;
  assign O_DATA_BYTE_INDEX = page_r.data_byte_index;
  assign O_OBJ_IRQ = irq_r;
  assign O_CAN_IRQ = any_r;

endmodule

// [tb/cbt_props.sv]
`timescale 1ns/1ns
// =====
// Port checks
module cbt_props #(
  parameter int NUM_OBJ = 15
) (
  // Clock, reset, register port
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic [7:0] O_SFR_RDATA,
  // Events and outputs
  input wire logic I_CONTROLLER_ENABLE,
  input wire logic [NUM_OBJ-1:0] I_OBJ_IRQ_STATUS,
  input wire logic I_DATA_ACCESS,
  input wire logic [3:0] O_OBJECT_SELECT,
  input wire logic [2:0] O_DATA_BYTE_INDEX,
  input wire logic [NUM_OBJ-1:0] O_OBJ_IRQ,
  input wire logic O_BIT_START,
  input wire logic O_SAMPLE_POINT
);
  logic [7:0] ie2_r, ie2_nxt;
  logic pw, iw;
  assign pw = I_SFR_WR && I_SFR_ADDR == cbt_pkg::ADDR_PAGE;
  assign iw = I_SFR_WR && I_SFR_ADDR == cbt_pkg::ADDR_IE2;
  always_comb begin
    ie2_nxt = I_RST ? 8'h00 : (iw ? I_SFR_WDATA : ie2_r);
  end
  always_ff @(posedge I_CLOCK) begin
    ie2_r <= ie2_nxt;
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  a_irq_status_gate: assert property (
    (O_OBJ_IRQ & ~$past(I_OBJ_IRQ_STATUS)) == '0)
    else $error("irq without status");
  a_low_mask_read: assert property (
    I_SFR_RD && !I_SFR_WR && I_SFR_ADDR == cbt_pkg::ADDR_IE2
    |=> O_SFR_RDATA == ie2_r) else $error("low mask readback");
  a_high_reserved: assert property (
    I_SFR_RD && I_SFR_ADDR == cbt_pkg::ADDR_IE1 |=> !O_SFR_RDATA[7])
    else $error("reserved bit set");
  a_page_fields: assert property (
    pw |=> {O_OBJECT_SELECT, 1'b0, O_DATA_BYTE_INDEX}
    == ($past(I_SFR_WDATA) & 8'hF7)) else $error("page fields");
  a_object_steady: assert property (
    !pw |=> $stable(O_OBJECT_SELECT)) else $error("object moved");
  a_index_cause: assert property (
    $changed(O_DATA_BYTE_INDEX) |-> $past(I_DATA_ACCESS) || $past(pw))
    else $error("index moved alone");
  a_index_step: assert property (
    $past(I_DATA_ACCESS) && !$past(I_SFR_WR) && $changed(O_DATA_BYTE_INDEX)
    |-> O_DATA_BYTE_INDEX == $past(O_DATA_BYTE_INDEX) + 3'h1)
    else $error("index step");
  a_edge_exclusive: assert property (
    !(O_SAMPLE_POINT && O_BIT_START)) else $error("pulses together");
  a_quiet_disabled: assert property (
    !I_CONTROLLER_ENABLE [*2] |=> !O_SAMPLE_POINT && !O_BIT_START)
    else $error("timing while disabled");
  a_low_irq_gate: assert property (
    O_OBJ_IRQ[7:0] == ($past(I_OBJ_IRQ_STATUS[7:0]) & $past(ie2_r)))
    else $error("low irq gate");
endmodule
bind cbt_top cbt_props #(.NUM_OBJ(NUM_OBJ)) u_props (
  .I_CLOCK, .I_RST, .I_SFR_ADDR, .I_SFR_WR, .I_SFR_RD, .I_SFR_WDATA,
  .O_SFR_RDATA, .I_CONTROLLER_ENABLE, .I_OBJ_IRQ_STATUS, .I_DATA_ACCESS,
  .O_OBJECT_SELECT, .O_DATA_BYTE_INDEX, .O_OBJ_IRQ, .O_BIT_START,
  .O_SAMPLE_POINT);

// [tb/cbt_can_node.sv]
`timescale 1ns/1ns
// =====
// Remote node, own slightly slow bit clock
module cbt_can_node (
  // Control
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic [7:0] i_bits,
  input wire logic [7:0] i_bit_clks,
  // Bus level, recessive when idle
  output logic o_rx
);
  initial o_rx = 1'b1;
  always @(posedge i_clk) begin
    if (i_send) begin
      for (int i = 7; i >= 0; i--) begin
        o_rx <= i_bits[i];
        repeat (i_bit_clks) @(posedge i_clk);
      end
      o_rx <= 1'b1;
    end
  end
endmodule

// [tb/cbt_top_tb.sv]
`timescale 1ns/1ns
// =====
// Bench
module cbt_top_tb;
  logic clk, rst, wr, rd, en, acc, rx, send, can_irq, bst, spt, rxb;
  logic [7:0] addr, wdata, rdata;
  logic [14:0] stat, irq;
  logic [3:0] obj;
  logic [2:0] idx;
  logic [7:0] ra [6] = '{8'hB1, 8'hB4, 8'hB5, 8'hB6, 8'hC2, 8'hC3};
  logic [7:0] rv [6] = '{8'hA5, 8'h7E, 8'h6E, 8'h7F, 8'h7F, 8'hFF};
  int num_errors = 0;
  int compares = 0;
  int n;
  cbt_top dut (.I_CLOCK(clk), .I_RST(rst), .I_SFR_ADDR(addr),
    .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
    .O_SFR_RDATA(rdata), .I_CONTROLLER_ENABLE(en),
    .I_OBJ_IRQ_STATUS(stat), .I_DATA_ACCESS(acc), .I_CAN_RX(rx),
    .O_OBJECT_SELECT(obj), .O_DATA_BYTE_INDEX(idx), .O_OBJ_IRQ(irq),
    .O_CAN_IRQ(can_irq), .O_BIT_START(bst), .O_SAMPLE_POINT(spt),
    .O_RX_BIT(rxb));
  cbt_can_node node (.i_clk(clk), .i_send(send), .i_bits(8'h33),
    .i_bit_clks(8'h0F), .o_rx(rx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({7'h00, rdata}, {7'h00, e});
  endtask
  task per(output int p);
    int k;
    k = 0;
    while (bst !== 1'b1 && k < 99) begin
      @(posedge clk);
      #1 k++;
    end
    p = 0;
    do begin
      @(posedge clk);
      #1 p++;
    end while (bst !== 1'b1 && p < 99);
  endtask
  task tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {rst, wr, rd, en, acc, send} = 6'h20;
    {addr, wdata, stat} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(cbt_pkg::ADDR_IE1, 8'h00);
    rd_chk(8'hB7, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr_reg(ra[i], rv[i]);
      rd_chk(ra[i], rv[i]);
    end
    $display("registers done");
    wr_reg(cbt_pkg::ADDR_IE1, 8'h0C);
    wr_reg(cbt_pkg::ADDR_IE2, 8'h0C);
    @(posedge clk) stat <= 15'h7FFF;
    repeat (3) @(posedge clk);
    #1 chk(irq, 15'h0C0C);
    chk({14'h0000, can_irq}, 15'h0001);
    wr_reg(cbt_pkg::ADDR_IE2, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(irq, 15'h0C00);
    @(posedge clk) stat <= 15'h0000;
    repeat (3) @(posedge clk);
    #1 chk(irq, 15'h0000);
    chk({14'h0000, can_irq}, 15'h0000);
    $display("interrupts done");
    wr_reg(cbt_pkg::ADDR_PAGE, 8'hE6);
    #1 chk({8'h00, obj, idx}, {8'h00, 4'hE, 3'h6});
    @(posedge clk) acc <= 1'b1;
    repeat (2) @(posedge clk);
    acc <= 1'b0;
    #1 chk({12'h000, idx}, 15'h0000);
    wr_reg(cbt_pkg::ADDR_PAGE, 8'hEB);
    @(posedge clk) acc <= 1'b1;
    @(posedge clk) acc <= 1'b0;
    #1 chk({12'h000, idx}, 15'h0003);
    $display("page done");
    wr_reg(cbt_pkg::ADDR_BT1, 8'h02);
    wr_reg(cbt_pkg::ADDR_BT2, 8'h02);
    wr_reg(cbt_pkg::ADDR_BT3, 8'h13);
    @(posedge clk) en <= 1'b1;
    per(n);
    per(n);
    chk(15'(n), 15'h000E);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (spt !== 1'b1 && n < 99);
    chk(15'(n), 15'h000A);
    chk({14'h0000, rxb}, 15'h0001);
    @(posedge clk) send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    repeat (25) @(posedge clk);
    #1 chk({14'h0000, rxb}, 15'h0000);
    for (int i = 0; i < 4; i++) begin
      per(n);
      chk(15'(n >= 12 && n <= 16), 15'h0001);
    end
    @(posedge clk) en <= 1'b0;
    $display("timing done");
    tally_and_finish();
  end
endmodule
